// *** impe_pkg.sv ***
// Purpose: shared constants and carriers of the two-wire bus master engine
// Assumes: link clock at LINK_KHZ, open-drain pads with pull-ups outside
// Notes: one command per handshake; the command word is held while busy
`default_nettype none

package impe_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int LINK_KHZ = 8000; // link clock rate in kHz
    localparam int MAX_BUS_KBPS = 400; // fast mode ceiling of the memory
    localparam int QUARTERS = 4; // quarter phases per bus bit
    localparam int MIN_Q_INT = (LINK_KHZ + QUARTERS * MAX_BUS_KBPS - 1) / (QUARTERS * MAX_BUS_KBPS);
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] MIN_QUARTER = DIV_W'(MIN_Q_INT);
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ACK_IDX = 4'(BYTE_BITS);
    localparam logic [1:0] Q_FIRST = 2'h0;
    localparam logic [1:0] Q_DATA = 2'h1;
    localparam logic [1:0] Q_RISE = 2'h2;
    localparam logic [1:0] Q_LAST = 2'h3;
    // ************************************************************
    // pin levels and reset values
    // ************************************************************
    localparam logic OE_OFF = 1'h1; // enable high: pin released
    localparam logic DRIVE = 1'h0; // enable low: pin pulled low
    localparam logic PIN_LOW = 1'h0;
    localparam logic WP_RST = 1'h0; // writes allowed after reset
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} impe_op_e;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP, ST_DONE} impe_st_e;
    typedef struct packed {
        impe_op_e op;
        logic [BYTE_BITS-1:0] data;
        logic ack;
        logic [DIV_W-1:0] div;
    } impe_cmd_s;
    typedef struct packed {
        logic [BYTE_BITS-1:0] data;
        logic nack;
        logic arb_lost;
        logic refused;
    } impe_rsp_s;
    typedef struct packed {
        impe_st_e st;
        logic [1:0] q;
        logic [DIV_W-1:0] cnt;
        logic [3:0] bitn;
        logic [BYTE_BITS-1:0] sh;
        impe_cmd_s cmd;
        impe_rsp_s rsp;
        logic owned;
        logic scl_oe_n;
        logic sda_oe_n;
        logic sda_m;
        logic sda_s;
        logic scl_m;
        logic scl_s;
        logic req_m;
        logic req_s;
        logic req_seen;
        logic ack_tgl;
    } impe_lnk_s;
    typedef struct packed {
        logic busy;
        logic req_tgl;
        impe_cmd_s cmd;
        logic ack_m;
        logic ack_s;
        logic ack_seen;
        logic rsp_valid;
        impe_rsp_s rsp;
        logic wp;
    } impe_core_s;
endpackage

`default_nettype wire

// *** impe_top.sv ***
// Purpose: two-wire bus master engine with open-drain clock and data pins
// Assumes: cmd held by the core domain while busy; pads resolve enables
// Notes: bit engine on link_clk, command side on core_clk, toggle handshake
`timescale 1ns/1ns
`default_nettype none

// Contract
// - start is data falling while clock is high.
// - stop is data rising while clock is high.
// - only the master makes start and stop; a slave never does.
// - the master drives every clock pulse and opens and closes transactions.
// - bytes are exactly eight bits; bytes per transfer are unlimited.
// - bits go most significant first, least significant last.
// - a ninth clock pulse after each byte carries the acknowledge.
// - the sender releases data for the whole acknowledge pulse.
// - the receiver acknowledges by holding data low through the high phase.
// - first byte after start is seven address bits plus direction bit.
// - after start the address byte goes before any data byte.
// - every transfer ends with a stop after the last acknowledge.
// - bit rate stays within 100, 400 or 3400 kbit/s by mode; the code has no modes and only clamps to the 400 kbit/s ceiling.
// - clock rate comes from a programmable divisor kept within slave rating.
// - one data wire carries output and input; slave data is sampled there.
// - write-protect output low for normal use, high blocks memory writes.
// - lines are only pulled low or released; pull-ups restore high.
// - arbitration detects a second master and stops corrupting data.
module impe_top
    import impe_pkg::*;
(
    input wire logic core_clk,
    input wire logic link_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    output var logic cmd_ready,
    input wire impe_cmd_s cmd,
    output var logic rsp_valid,
    output var impe_rsp_s rsp,
    input wire logic write_protect,
    output var logic low_byte_gpio_zero,
    output var logic serial_clock_out,
    output var logic serial_clock_oe_n,
    input wire logic serial_clock_in,
    output var logic serial_data_out,
    output var logic serial_data_oe_n,
    input wire logic serial_data_in
);

    // ************************************************************
    // core domain: command take-over and answer
    // ************************************************************
    impe_core_s cq;
    impe_core_s cn;
    impe_lnk_s lq;
    impe_lnk_s ln;

    // one command in flight; the word stays put until the link answers
    always_comb begin
        cn = cq;
        cn.rsp_valid = 1'h0;
        cn.ack_m = lq.ack_tgl;
        cn.ack_s = cq.ack_m;
        cn.ack_seen = cq.ack_s;
        cn.wp = write_protect;
        if (cq.ack_s != cq.ack_seen) begin
            cn.busy = 1'h0;
            cn.rsp_valid = 1'h1;
            cn.rsp = lq.rsp; // stable: link holds it until the next take
        end
        if (cmd_valid && !cq.busy) begin
            cn.cmd = cmd;
            cn.req_tgl = !cq.req_tgl;
            cn.busy = 1'h1;
        end
    end

    // core register bank
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cq <= '0;
            cq.wp <= WP_RST;
        end else begin
            cq <= cn;
        end
    end

    // handshake ready may be combinational, the rest comes from flops
    assign cmd_ready = !cq.busy;
    assign rsp_valid = cq.rsp_valid;
    assign rsp = cq.rsp;
    assign low_byte_gpio_zero = cq.wp;

    // ************************************************************
    // link domain: quarter timing
    // ************************************************************
    logic [DIV_W-1:0] qlen;
    logic stall;
    logic qend;
    logic go;
    logic rd;
    logic sda_bit;

    // a divisor below the floor would overrun the memory, so it is clamped
    assign qlen = (lq.cmd.div < MIN_QUARTER) ? MIN_QUARTER : lq.cmd.div;
    // released clock still seen low: slave stretching or another master
    assign stall = lq.scl_oe_n && !lq.scl_s;
    assign qend = (lq.cnt >= qlen - 1'h1) && !stall;
    assign go = lq.req_s != lq.req_seen;
    assign rd = lq.cmd.op == OP_READ;

    // data level for the current bit; read bits and the write ack float
    always_comb begin
        if (lq.bitn < ACK_IDX) begin
            sda_bit = rd ? OE_OFF : (lq.sh[BYTE_BITS-1] ? OE_OFF : DRIVE);
        end else begin
            sda_bit = (rd && lq.cmd.ack) ? DRIVE : OE_OFF;
        end
    end

    // ************************************************************
    // link domain: bit engine
    // ************************************************************
    always_comb begin
        ln = lq;
        // two-flop synchronisers for pins and the request toggle
        ln.sda_m = serial_data_in;
        ln.sda_s = lq.sda_m;
        ln.scl_m = serial_clock_in;
        ln.scl_s = lq.scl_m;
        ln.req_m = cq.req_tgl;
        ln.req_s = lq.req_m;
        ln.req_seen = lq.req_s;
        // quarter counter, frozen while the released clock line is still seen low
        if (!stall) begin
            ln.cnt = qend ? '0 : lq.cnt + 1'h1;
        end
        if (qend) begin
            ln.q = lq.q + 1'h1;
        end
        case (lq.st)
            ST_IDLE: begin
                ln.cnt = '0;
                ln.q = Q_FIRST;
                if (go) begin
                    ln.cmd = cq.cmd;
                    ln.rsp = '0;
                    ln.bitn = '0;
                    ln.sh = (cq.cmd.op == OP_READ) ? '0 : cq.cmd.data;
                    case (cq.cmd.op)
                        OP_START: ln.st = ST_START;
                        OP_STOP: ln.st = lq.owned ? ST_STOP : ST_DONE;
                        default: ln.st = lq.owned ? ST_BIT : ST_DONE;
                    endcase
                    // no byte or stop without a start first
                    ln.rsp.refused = !lq.owned && (cq.cmd.op != OP_START);
                end
            end
            ST_START: begin
                // clock low first when owned, so releasing data is never a stop
                case (lq.q)
                    Q_FIRST: ln.scl_oe_n = lq.owned ? DRIVE : OE_OFF;
                    Q_DATA: ln.sda_oe_n = OE_OFF;
                    Q_RISE: ln.scl_oe_n = OE_OFF;
                    default: ln.sda_oe_n = DRIVE;
                endcase
                if (qend && lq.q == Q_LAST) begin
                    ln.st = ST_BIT;
                    ln.bitn = '0;
                    ln.sh = lq.cmd.data;
                    ln.owned = 1'h1;
                end
            end
            ST_BIT: begin
                // data moves one quarter after the clock falls, never with it
                case (lq.q)
                    Q_FIRST: ln.scl_oe_n = DRIVE;
                    Q_DATA: ln.sda_oe_n = sda_bit;
                    Q_RISE: ln.scl_oe_n = OE_OFF;
                    default: ;
                endcase
                if (qend && lq.q == Q_LAST) begin
                    if (lq.bitn < ACK_IDX) begin
                        ln.sh = {lq.sh[BYTE_BITS-2:0], lq.sda_s};
                        ln.bitn = lq.bitn + 1'h1;
                        // released a one but the wire reads zero: someone else won
                        if (!rd && lq.sda_oe_n && !lq.sda_s) begin
                            ln.rsp.arb_lost = 1'h1;
                            ln.rsp.data = lq.sh;
                            ln.owned = 1'h0;
                            ln.scl_oe_n = OE_OFF;
                            ln.sda_oe_n = OE_OFF;
                            ln.st = ST_DONE;
                        end
                    end else begin
                        ln.rsp.data = lq.sh;
                        ln.rsp.nack = lq.sda_s;
                        ln.st = ST_DONE;
                    end
                end
            end
            ST_STOP: begin
                case (lq.q)
                    Q_FIRST: ln.scl_oe_n = DRIVE;
                    Q_DATA: ln.sda_oe_n = DRIVE;
                    Q_RISE: ln.scl_oe_n = OE_OFF;
                    default: ln.sda_oe_n = OE_OFF;
                endcase
                if (qend && lq.q == Q_LAST) begin
                    ln.owned = 1'h0;
                    ln.st = ST_DONE;
                end
            end
            ST_DONE: begin
                // answer already settled one cycle before the toggle
                ln.ack_tgl = !lq.ack_tgl;
                ln.st = ST_IDLE;
            end
            default: ln.st = ST_IDLE;
        endcase
    end

    // link register bank; pads come up released
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            lq <= '0;
            lq.st <= ST_IDLE;
            lq.scl_oe_n <= OE_OFF;
            lq.sda_oe_n <= OE_OFF;
        end else begin
            lq <= ln;
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    // open drain: output level is always low, only the enable moves
    assign serial_clock_out = PIN_LOW;
    assign serial_data_out = PIN_LOW;
    assign serial_clock_oe_n = lq.scl_oe_n;
    assign serial_data_oe_n = lq.sda_oe_n;

    // ************************************************************
    // checks
    // ************************************************************
    AST_START_ONLY: assert property (
        @(posedge link_clk) disable iff (!resetn)
        ($fell(lq.sda_oe_n) && lq.scl_oe_n) |-> (lq.st == ST_START))
        else $error("data pulled low with clock high outside start");

    AST_STOP_ONLY: assert property (
        @(posedge link_clk) disable iff (!resetn)
        ($rose(lq.sda_oe_n) && lq.scl_oe_n) |-> (lq.st == ST_STOP))
        else $error("data released with clock high outside stop");

    AST_MSB_FIRST: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_BIT && !rd && lq.bitn < ACK_IDX && lq.q == Q_LAST)
        |-> (lq.sda_oe_n == lq.sh[BYTE_BITS-1]))
        else $error("write bit on the wire is not the top shift bit");

    AST_ACK_RELEASE: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_BIT && !rd && lq.bitn == ACK_IDX && lq.q >= Q_RISE)
        |-> lq.sda_oe_n)
        else $error("data held during slave acknowledge");

    AST_READ_RELEASE: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_BIT && rd && lq.bitn < ACK_IDX && lq.q >= Q_RISE)
        |-> lq.sda_oe_n)
        else $error("data driven while reading slave bits");

    AST_IDLE_RELEASE: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_IDLE && !lq.owned) |-> (lq.scl_oe_n && lq.sda_oe_n))
        else $error("bus not released while not owned");

    AST_CLOCK_HIGH_MIN: assert property (
        @(posedge link_clk) disable iff (!resetn)
        $rose(lq.scl_oe_n) |-> (lq.scl_oe_n) [*8])
        else $error("clock high phase shorter than the rate floor");

    AST_REFUSE_NO_START: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_IDLE && go && !lq.owned && cq.cmd.op != OP_START)
        |=> (lq.st == ST_DONE && lq.rsp.refused) ##1 (lq.st == ST_IDLE))
        else $error("byte or stop accepted without a start");

    AST_ARB_RELEASE: assert property (
        @(posedge link_clk) disable iff (!resetn)
        $rose(lq.rsp.arb_lost) |-> (lq.scl_oe_n && lq.sda_oe_n && lq.st == ST_DONE && !lq.owned))
        else $error("lines still driven after lost arbitration");

    AST_PINS_LOW_ONLY: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (serial_clock_out == PIN_LOW && serial_data_out == PIN_LOW))
        else $error("pin output level is not low");

    AST_ACK_PULSE: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_BIT && qend && lq.q == Q_LAST && lq.bitn == ACK_IDX) |=> (lq.st == ST_DONE))
        else $error("byte did not end after its acknowledge pulse");

    AST_BYTE_LEN: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_BIT) |-> (lq.bitn <= ACK_IDX))
        else $error("bit counter ran past the acknowledge slot");

    AST_CLOCK_LOW_DATA: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_BIT && lq.q == Q_DATA) |-> !lq.scl_oe_n)
        else $error("data quarter with the clock not pulled low");

    AST_START_OWNS: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_START && qend && lq.q == Q_LAST) |=> (lq.st == ST_BIT && lq.owned && lq.bitn == '0))
        else $error("start not followed by the address byte");

    AST_STOP_FREES: assert property (
        @(posedge link_clk) disable iff (!resetn)
        (lq.st == ST_STOP && qend && lq.q == Q_LAST) |=> (lq.st == ST_DONE && !lq.owned && lq.scl_oe_n && lq.sda_oe_n))
        else $error("stop did not release the bus");

    AST_WP_FOLLOWS: assert property (
        @(posedge core_clk) disable iff (!resetn)
        1'b1 |=> (low_byte_gpio_zero == $past(write_protect)))
        else $error("write-protect output does not follow its input");

    AST_RSP_ONE_CYCLE: assert property (
        @(posedge core_clk) disable iff (!resetn)
        rsp_valid |=> !rsp_valid)
        else $error("answer strobe longer than one cycle");

endmodule // impe_top

`default_nettype wire

// *** impe_mem_model.sv ***
// Purpose: behavioural two-wire memory slave that faces impe_top
// Assumes: open-drain wires with pull-ups, resolved by the bench
// Notes: first data byte after a write address loads the pointer
`timescale 1ns/1ns
`default_nettype none
module impe_mem_model #(
    parameter logic [3:0] DEV_HI = 4'h5, // arbitrary device type value
    parameter logic [2:0] SEL = 3'h3 // levels of the address select pins
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic wp,
    input wire logic stretch,
    output var logic scl_low,
    output var logic sda_low
);
    // ************
    // slave state
    // ************
    logic [7:0] mem [256];
    logic [7:0] sh, ptr;
    logic act = 1'b0, first, rd = 1'b0, mack, have_ptr;
    int nb = 0;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // start and stop are only watched; the model moves data with clock low, so it never makes them
    always @(sda) begin
        if (scl === 1'b1) begin
            act = !sda;
            sda_low = 1'b0;
            first = 1'b1;
            rd = 1'b0;
            have_ptr = 1'b0;
            // the clock fall that opens the first bit brings this to zero
            nb = -1;
        end
    end
    // rising clock: shift written bits, or take the master's acknowledge
    always @(posedge scl) begin
        mack = (nb == 8) ? !sda : mack;
        if (act && nb < 8 && !rd) begin
            sh = {sh[6:0], sda};
        end
    end
    // falling clock: change data; a slow partner holds the clock low past the master's quarter
    always @(negedge scl) begin
        if (act) begin
            if (stretch) begin
                scl_low = 1'b1;
                scl_low <= #2000 1'b0;
            end
            nb = nb + 1;
            if (nb == 8 && first) begin
                first = 1'b0;
                act = (sh[7:1] == {DEV_HI, SEL});
                rd = sh[0];
                mack = 1'b1;
                sda_low = act;
            end else if (nb == 8 && !rd) begin
                // write protect blocks the store but the byte is still acknowledged
                if (have_ptr && !wp) begin
                    mem[ptr] = sh;
                end
                ptr = have_ptr ? ptr + 8'h01 : sh;
                have_ptr = 1'b1;
                sda_low = 1'b1;
            end else begin
                if (nb == 9) begin
                    nb = 0;
                    if (rd && mack) begin
                        sh = mem[ptr];
                        ptr = ptr + 8'h01;
                    end
                end
                sda_low = rd && mack && nb < 8 && !sh[7 - nb];
            end
        end
    end
endmodule // impe_mem_model
`default_nettype wire

// *** impe_top_bench.sv ***
// Purpose: self-checking bench of impe_top beside a two-wire memory model
// Assumes: pull-ups on both wires, link clock 125 ns unrelated to core clock
// Notes: expectations queue at command take and are checked at rsp_valid
`timescale 1ns/1ns
`default_nettype none
module impe_top_bench
    import impe_pkg::*;
;
    // ************
    // stimulus and checks
    // ************
    typedef struct packed {impe_rsp_s r; logic [10:0] m;} impe_exp_s;
    localparam logic [6:0] SLV = 7'h2B; // model device type and select levels
    localparam logic [10:0] FULL = 11'h7FF;
    localparam logic [10:0] FLAGS = 11'h003; // arb_lost and refused only
    logic core_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, write_protect = 1'b0;
    logic stretch = 1'b0, rogue_low = 1'b0, cmd_ready, rsp_valid, gpio, scl_oe_n, sda_oe_n, scl_o, sda_o;
    logic scl_low, sda_low, scl_w, sda_w;
    logic [7:0] ptr, b;
    logic [7:0] shadow [256];
    impe_cmd_s cmd = '0;
    impe_rsp_s rsp;
    impe_exp_s exp_q [$];
    int n_fail = 0, total_checks = 0, seed = 42, cyc = 0;
    time t_rise = 0;
    // open-drain wires: low while anyone pulls, pull-up otherwise
    assign scl_w = !(scl_oe_n === DRIVE || scl_low);
    assign sda_w = !(sda_oe_n === DRIVE || sda_low || rogue_low);
    always #25 core_clk = ~core_clk;
    initial begin
        #17;
        forever begin
            #62 link_clk = 1'b1;
            #63 link_clk = 1'b0;
        end
    end
    impe_top DUT (.core_clk(core_clk), .link_clk(link_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .write_protect(write_protect),
        .low_byte_gpio_zero(gpio), .serial_clock_out(scl_o), .serial_clock_oe_n(scl_oe_n),
        .serial_clock_in(scl_w), .serial_data_out(sda_o), .serial_data_oe_n(sda_oe_n), .serial_data_in(sda_w));
    impe_mem_model #(.DEV_HI(4'h5), .SEL(3'h3)) partner (.scl(scl_w), .sda(sda_w), .wp(gpio),
        .stretch(stretch), .scl_low(scl_low), .sda_low(sda_low));
    task automatic chk_rsp(impe_rsp_s got, impe_exp_s e);
        total_checks++;
        if ((got & e.m) !== (e.r & e.m)) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, e.r);
        end
    endtask
    task automatic chk_bit(logic got, logic e);
        total_checks++;
        if (got !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, e);
        end
    endtask
    // offer one command, held until taken; the answer is expected in order
    task automatic issue(impe_op_e op, logic [7:0] d, logic a, logic [10:0] e, logic [10:0] m);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, d, a, 16'({$random(seed)} % 10)};
        do @(negedge core_clk); while (cmd_ready !== 1'b1);
        @(posedge core_clk);
        exp_q.push_back('{e, m});
        cmd_valid <= 1'b0;
    endtask
    task automatic wait_idle;
        while (exp_q.size() != 0) @(negedge core_clk);
    endtask
    task automatic finish_bus;
        issue(OP_STOP, 8'h00, 1'b0, 11'h000, FLAGS);
        wait_idle;
        chk_bit(scl_oe_n & sda_oe_n, OE_OFF);
    endtask
    task automatic write_at(logic [7:0] p, int n, logic prot);
        issue(OP_START, {SLV, 1'b0}, 1'b0, {SLV, 4'h0}, FULL);
        issue(OP_WRITE, p, 1'b0, {p, 3'h0}, FULL);
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            if (!prot) shadow[p + 8'(i)] = b;
            issue(OP_WRITE, b, 1'b0, {b, 3'h0}, FULL);
        end
    endtask
    // repeated start into read; the last byte is not acknowledged
    task automatic read_at(logic [7:0] p, int n);
        write_at(p, 0, 1'b0);
        issue(OP_START, {SLV, 1'b1}, 1'b0, {SLV, 1'b1, 3'h0}, FULL);
        for (int i = 0; i < n; i++) begin
            issue(OP_READ, 8'h00, i < n - 1, {shadow[p + 8'(i)], i == n - 1, 2'h0}, FULL);
        end
        finish_bus;
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // answers are taken at the falling edge, where the one-cycle pulse is settled
    always @(negedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            chk_rsp(rsp, exp_q.size() != 0 ? exp_q.pop_front() : impe_exp_s'{~rsp, FULL});
        end
    end
    // bit rate: clock rises at least a 400 kbit/s bit apart; pins only ever pull low
    always @(posedge scl_w) begin
        if (t_rise != 0) begin
            chk_bit(($time - t_rise) >= 2500, 1'b1);
            chk_bit(scl_o | sda_o, PIN_LOW);
        end
        t_rise = $time;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            $display("CHECK FAILED at %0t timeout", $time);
            report_and_stop;
        end
    end
    initial begin
        // reset held past two link edges, then settling time for the toggle sync
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(negedge core_clk);
        chk_bit(cmd_ready & !rsp_valid, 1'b1);
        chk_bit(scl_oe_n & sda_oe_n, OE_OFF);
        chk_bit(gpio, WP_RST);
        repeat (10) @(posedge core_clk);
        issue(OP_WRITE, 8'h00, 1'b0, 11'h001, FLAGS);
        ptr = 8'($random(seed));
        write_at(ptr, 4, 1'b0);
        finish_bus;
        stretch <= 1'b1;
        read_at(ptr, 4);
        stretch <= 1'b0;
        issue(OP_START, {SLV ^ 7'h01, 1'b0}, 1'b0, {SLV ^ 7'h01, 2'h1, 2'h0}, FULL);
        finish_bus;
        @(posedge core_clk);
        write_protect <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk_bit(gpio, 1'b1);
        write_at(ptr, 2, 1'b1);
        finish_bus;
        @(posedge core_clk);
        write_protect <= 1'b0;
        read_at(ptr, 2);
        // a second master holds data low while this one sends ones
        issue(OP_START, 8'hFF, 1'b0, 11'h002, FLAGS);
        @(negedge scl_w);
        @(posedge core_clk);
        rogue_low <= 1'b1;
        wait_idle;
        @(posedge core_clk);
        rogue_low <= 1'b0;
        issue(OP_WRITE, 8'h00, 1'b0, 11'h001, FLAGS);
        issue(OP_STOP, 8'h00, 1'b0, 11'h001, FLAGS);
        wait_idle;
        chk_bit(scl_oe_n & sda_oe_n, OE_OFF);
        report_and_stop;
    end
endmodule // impe_top_bench
`default_nettype wire
